// ==== sim/fsbs_checker.sv ====
// ========================================
// Port checks of the burst memory
module fsbs_checker
	import fsbs_pkg::*;
#(
	parameter int LANES = 4
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic burst_advance,
	input wire logic write_strobe_n,
	input wire logic clk_qual_n,
	input wire logic chip_sel_first_n,
	input wire logic chip_sel_second,
	input wire logic chip_sel_third_n,
	input wire logic out_en_n,
	input wire logic sleep_request,
	input wire logic [LANES*LANE_W-1:0] dq_out,
	input wire logic dq_oe,
	input wire logic low_power
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] slp_q; // Recent sleep pin history
	logic [2:0] slp_d;
	logic sel; // All three selects true
	logic go; // Edge taken, well clear of sleep

	// ========================================
	// Sleep history, so edges near a change are skipped
	always_comb begin
		slp_d = {slp_q[1:0], sleep_request};
	end
	always_ff @(posedge clock) begin
		slp_q <= slp_d;
	end
	assign sel = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
	assign go = !clk_qual_n && !sleep_request && slp_q == 3'h0;

	// ========================================
	// Properties
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	a_oe_async: assert property (out_en_n |-> !dq_oe)
		else $error("drivers on with enable pin high");
	a_read_drive: assert property (go && !burst_advance && sel &&
		write_strobe_n ##1 !out_en_n |-> dq_oe)
		else $error("read load left drivers off");
	a_write_off: assert property (go && !burst_advance && sel &&
		!write_strobe_n |=> !dq_oe)
		else $error("drivers on in write data phase");
	a_hold_data: assert property (clk_qual_n |=> $stable(dq_out))
		else $error("read data moved on suspended edge");
	a_hold_drive: assert property (clk_qual_n && !out_en_n &&
		!sleep_request && slp_q == 3'h0 ##1 !out_en_n |-> $stable(dq_oe))
		else $error("drive state moved on suspended edge");
	a_deselect_power: assert property (go && !burst_advance && !sel
		|=> low_power)
		else $error("no low power after deselect");
	a_sleep_power: assert property (sleep_request [*4] |=> low_power)
		else $error("no low power in sleep");
	a_read_awake: assert property (go && !burst_advance && sel &&
		write_strobe_n |=> !low_power)
		else $error("low power during selected read");
endmodule : fsbs_checker

bind fsbs_top fsbs_checker #(.LANES(LANES)) chk (.*);

// ==== sim/fsbs_ctrl.sv ====
// ========================================
// Controller on the far side of the bus
module fsbs_ctrl
	import fsbs_pkg::*;
#(
	parameter int LANES = 4,
	parameter int ADDR_W = 6
) (
	output logic [ADDR_W-1:SEED_W] addr_hi,
	output logic burst_seed_bit1,
	output logic burst_seed_bit0,
	output logic burst_advance,
	output logic write_strobe_n,
	output logic [LANES-1:0] byte_lane_sel_n,
	output logic clk_qual_n,
	output logic chip_sel_first_n,
	output logic chip_sel_second,
	output logic chip_sel_third_n,
	output logic out_en_n,
	output logic sleep_request,
	output logic burst_interleave,
	output logic [LANES*LANE_W-1:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// Puts one cycle of controls and data on the pins
	task drv(input logic [8:0] c, input logic [ADDR_W-1:0] a,
		input logic [LANES-1:0] ln, input logic [LANES*LANE_W-1:0] d);
		{clk_qual_n, burst_advance, write_strobe_n} = c[8:6];
		{chip_sel_first_n, chip_sel_second, chip_sel_third_n} = c[5:3];
		{out_en_n, sleep_request, burst_interleave} = c[2:0];
		{addr_hi, burst_seed_bit1, burst_seed_bit0} = a;
		byte_lane_sel_n = ln;
		dq_in = d; // Caller's pattern, held on the pins until the next call
	endtask : drv

	// Suspended and deselected at time zero
	initial begin
		drv(9'h16C, '0, '1, '0);
	end
endmodule : fsbs_ctrl

// ==== sim/tb.sv ====
// ========================================
// Bench with a behavioural memory model
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import fsbs_pkg::*;
	localparam int LN = 4;
	localparam int AW = 6;
	localparam int DW = LN * LANE_W;
	logic clock = 1'h0;
	logic rst_b = 1'h0;
	logic tck = 1'h0;
	logic tms = 1'h1;
	logic tdi = 1'h0;
	logic [AW-1:SEED_W] addr_hi;
	logic burst_seed_bit1, burst_seed_bit0, burst_advance, write_strobe_n;
	logic clk_qual_n, chip_sel_first_n, chip_sel_second, chip_sel_third_n;
	logic out_en_n, sleep_request, burst_interleave, dq_oe, low_power;
	logic tdo, tdo_oe;
	logic [LN-1:0] byte_lane_sel_n;
	logic [DW-1:0] dq_in, dq_out;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [DW-1:0] mem [int]; // Model array
	logic [DW-1:0] last; // Model of held read data
	logic [LN-1:0] pl; // Lanes of pending write
	int kind = 0; // 0 none, 1 read, 2 write
	int drive = 0;
	int pw = 0;
	int base, seed, cnt, il, pa, sv;

	fsbs_ctrl #(.LANES(LN), .ADDR_W(AW)) ctl (.*);
	fsbs_top #(.LANES(LN), .ADDR_W(AW)) DUT (.*);

	// Clock and hang limit
	always #20 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			report_and_stop();
		end
	end

	task report_and_stop;
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	task cmp(input logic [DW-1:0] g, input logic [DW-1:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %0t data %h expected %h", $time, g, e);
		end
	endtask : cmp

	task cmpb(input logic g, input logic e, input string s);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %0t %s is %b", $time, s, g);
		end
	endtask : cmpb

	// One scan clock period, pins held four clocks per phase
	task tap_bit(input logic m, input logic i);
		tms = m;
		tdi = i;
		repeat (4) @(posedge clock);
		#1;
		tck = 1'h1;
		repeat (4) @(posedge clock);
		#1;
		tck = 1'h0;
		repeat (4) @(posedge clock);
		#1;
	endtask : tap_bit

	// One bus cycle: check the last edge, model and drive the next
	task op(input logic q, adv, wn, input logic [2:0] cs,
		input logic [AW-1:0] a, input logic [LN-1:0] ln, input logic oen, slp);
		logic [DW-1:0] d;
		int w;
		@(posedge clock);
		#1;
		d = DW'({$urandom, $urandom});
		cmp(dq_out, last);
		cmpb(dq_oe, drive != 0 && !out_en_n, "drive");
		cmpb(low_power, kind == 0, "low power");
		if (!q && !slp) begin
			for (int i = 0; i < LN; i++)
				if (pw != 0 && !pl[i])
					mem[pa][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
			if (!adv) begin
				kind = cs == 3'h2 ? (wn ? 1 : 2) : 0;
				base = int'(a) / 4;
				seed = int'(a) % 4;
				cnt = 0;
			end else if (kind != 0)
				cnt = (cnt + 1) % 4;
			w = base * 4 + (il != 0 ? seed ^ cnt : (seed + cnt) % 4);
			if (kind == 1)
				last = mem[w];
			pw = kind == 2;
			pa = w;
			pl = ln;
			drive = kind == 1;
		end else if (slp)
			drive = 0;
		ctl.drv({q, adv, wn, cs, oen, slp, 1'(il)}, a, ln, d);
	endtask : op

	// ========================================
	// Main sequence
	initial begin
		sv = $urandom(32'h5835);
		il = 0;
		repeat (16) @(posedge clock);
		#1;
		rst_b = 1'h1;
		for (int b = 0; b < 16; b++)
			for (int k = 0; k < 4; k++)
				op(0, k != 0, 0, 3'h2, AW'(b * 4), 4'h0, 0, 0);
		for (int m = 0; m < 2; m++) begin
			il = m;
			op(0, 0, 1, 3'h0, 0, 0, 0, 0);
			repeat (150)
				op(($urandom % 4) == 0, 1'($urandom), 1'($urandom),
					($urandom % 4) != 0 ? 3'h2 : 3'($urandom), AW'($urandom),
					LN'($urandom), ($urandom % 8) == 0, 0);
		end
		op(0, 0, 1, 3'h5, 0, 0, 0, 0);
		repeat (4) op(1, 0, 1, 3'h2, 0, 0, 0, 1);
		repeat (4) op(0, 0, 1, 3'h2, AW'($urandom), 0, 0, 1);
		repeat (4) op(1, 0, 1, 3'h2, 0, 0, 0, 0);
		op(0, 0, 1, 3'h2, AW'($urandom), 0, 0, 0);
		op(1, 1, 1, 3'h2, 0, 0, 0, 0);
		op(1, 1, 1, 3'h2, 0, 0, 1, 0);
		op(1, 1, 1, 3'h2, 0, 0, 0, 0);
		// Scan port: walk to the data shift and read the identification
		tap_bit(0, 0);
		tap_bit(1, 0);
		tap_bit(0, 0);
		for (int k = 0; k < ID_W; k++) begin
			tap_bit(0, 1'($urandom));
			cmpb(tdo, ID_DEFAULT[k], "scan out");
			cmpb(tdo_oe, 1'h1, "scan drive");
		end
		tap_bit(1, 0);
		cmpb(tdo_oe, 1'h0, "scan drive");
		report_and_stop();
	end
endmodule : tb

// ==== verilog/fsbs_mem.sv ====
// ========================================
// Storage array with per-lane write and registered read
module fsbs_mem #(
	parameter int ADDR_W = 21,
	parameter int LANES = 4,
	parameter int LANE_W = 9
) (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [LANES-1:0] wr_lanes,
	input wire logic [LANES*LANE_W-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [LANES*LANE_W-1:0] rd_data
);

	logic [LANES*LANE_W-1:0] mem_q [2**ADDR_W]; // Word array
	logic [LANES*LANE_W-1:0] rd_data_d; // Read word with write bypass

	// ========================================
	// Read word, newest lanes win when addresses collide
	always_comb begin
		rd_data_d = mem_q[rd_addr];
		if (wr_en && (wr_addr == rd_addr)) begin
			for (int i = 0; i < LANES; i++) begin
				if (wr_lanes[i]) begin
					rd_data_d[i*LANE_W +: LANE_W] = wr_data[i*LANE_W +: LANE_W];
				end
			end
		end
	end

	// ========================================
	// Lane writes and read register
	always_ff @(posedge clock) begin
		if (wr_en) begin
			for (int i = 0; i < LANES; i++) begin
				if (wr_lanes[i]) begin
					mem_q[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
				end
			end
		end
		if (rd_en) begin
			rd_data <= rd_data_d;
		end
	end

endmodule : fsbs_mem

// ==== verilog/fsbs_pkg.sv ====
package fsbs_pkg;

	// ========================================
	// Array shape
	localparam int LANE_W = 9; // Byte lane: eight data bits plus parity
	localparam int LANES_X36 = 4; // Lanes of the wide variant
	localparam int LANES_X18 = 2; // Lanes of the narrow variant
	localparam int ADDR_W_X36 = 21; // Word address bits, 2M words
	localparam int ADDR_W_X18 = 22; // Word address bits, 4M words
	localparam int SEED_W = 2; // Burst counter width

	// ========================================
	// Access stage states
	typedef enum logic [2:0] {
		OP_IDLE = 3'h1, // Deselected, nothing in flight
		OP_READ = 3'h2, // Read burst running
		OP_WRITE = 3'h4 // Write burst running
	} fsbs_op_t;

	// ========================================
	// Test access port
	typedef enum logic [15:0] {
		TAP_RESET = 16'h0001,
		TAP_IDLE = 16'h0002,
		TAP_SEL_DR = 16'h0004,
		TAP_CAP_DR = 16'h0008,
		TAP_SHIFT_DR = 16'h0010,
		TAP_EXIT1_DR = 16'h0020,
		TAP_PAUSE_DR = 16'h0040,
		TAP_EXIT2_DR = 16'h0080,
		TAP_UPD_DR = 16'h0100,
		TAP_SEL_IR = 16'h0200,
		TAP_CAP_IR = 16'h0400,
		TAP_SHIFT_IR = 16'h0800,
		TAP_EXIT1_IR = 16'h1000,
		TAP_PAUSE_IR = 16'h2000,
		TAP_EXIT2_IR = 16'h4000,
		TAP_UPD_IR = 16'h8000
	} fsbs_tap_t;

	localparam int IR_W = 3; // Instruction register width
	localparam int ID_W = 32; // Identification register width
	localparam logic [IR_W-1:0] IR_IDCODE = 3'h1; // Read identification
	localparam logic [IR_W-1:0] IR_BYPASS = 3'h7; // One-bit bypass
	localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1; // Fixed capture pattern
	localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0000_0001; // Arbitrary value

	// ========================================
	// Burst address within a group of four words
	function automatic logic [SEED_W-1:0] burst_offset(
		input logic [SEED_W-1:0] seed,
		input logic [SEED_W-1:0] cnt,
		input logic interleave
	);
		burst_offset = interleave ? (seed ^ cnt) : SEED_W'(seed + cnt);
	endfunction : burst_offset

endpackage : fsbs_pkg

// ==== verilog/fsbs_top.sv ====
// Function
// - 2Mx36 or 4Mx18 organisation by parameter
// - All synchronous inputs captured on rising edge
// - Qualifier high freezes edge and burst state
// - Back-to-back reads and writes, no dead cycles
// - Read data flows from just-captured address
// - Write strobe plus per-lane selects, own lane
// - Writes complete internally, self timed
// - Selected only when all three selects true
// - Output enable high tri-states data asynchronously
// - Drivers off during write data phase
// - Output turnaround handled internally
// - Linear or interleaved burst order input
// - Low power on sleep request or deselect
// - Boundary-scan test access port provided
// - Two low address bits seed burst counter
// - Lane selects act only with write strobe
module fsbs_top
	import fsbs_pkg::*;
#(
	parameter int LANES = fsbs_pkg::LANES_X36,
	parameter int ADDR_W = fsbs_pkg::ADDR_W_X36,
	parameter logic [fsbs_pkg::ID_W-1:0] ID_CODE = fsbs_pkg::ID_DEFAULT
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:fsbs_pkg::SEED_W] addr_hi,
	input wire logic burst_seed_bit1,
	input wire logic burst_seed_bit0,
	input wire logic burst_advance,
	input wire logic write_strobe_n,
	input wire logic [LANES-1:0] byte_lane_sel_n,
	input wire logic clk_qual_n,
	input wire logic chip_sel_first_n,
	input wire logic chip_sel_second,
	input wire logic chip_sel_third_n,
	input wire logic out_en_n,
	input wire logic sleep_request,
	input wire logic burst_interleave,
	input wire logic [LANES*fsbs_pkg::LANE_W-1:0] dq_in,
	output logic [LANES*fsbs_pkg::LANE_W-1:0] dq_out,
	output logic dq_oe,
	output logic low_power,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe
);

	import fsbs_pkg::*;

	localparam int DATA_W = LANES * LANE_W; // Data bus width

	// ========================================
	// Build checks
	if (!((LANES == LANES_X36) || (LANES == LANES_X18))) begin : g_bad_lanes
		$error("fsbs_top: LANES must be 4 or 2");
	end
	if ((ADDR_W <= SEED_W) || (ADDR_W > ADDR_W_X18)) begin : g_bad_addr
		$error("fsbs_top: ADDR_W out of range");
	end

	// ========================================
	// Pin synchronisers for sleep and scan pins
	logic [3:0] sync1_q; // First stage, read only by second
	logic [3:0] sync2_q; // Second stage
	logic tck_prev_q; // Last synchronised scan clock
	logic sleep_s; // Synchronised sleep request
	logic tck_s; // Synchronised scan clock
	logic tms_s; // Synchronised mode select
	logic tdi_s; // Synchronised scan data in
	logic tck_rise; // Scan clock rising
	logic tck_fall; // Scan clock falling

	always_ff @(posedge clock) begin
		sync1_q <= {sleep_request, tck, tms, tdi};
		sync2_q <= sync1_q;
		tck_prev_q <= tck_s;
	end

	assign {sleep_s, tck_s, tms_s, tdi_s} = sync2_q;
	assign tck_rise = tck_s & ~tck_prev_q;
	assign tck_fall = ~tck_s & tck_prev_q;

	// ========================================
	// Access stage
	fsbs_op_t op_q, op_d; // Burst type in flight
	logic [ADDR_W-1:SEED_W] base_q, base_d; // Burst base address
	logic [SEED_W-1:0] seed_q, seed_d; // Burst start offset
	logic [SEED_W-1:0] cnt_q, cnt_d; // Burst position
	logic wr_pend_q, wr_pend_d; // Write data due this edge
	logic [ADDR_W-1:0] wr_addr_q, wr_addr_d; // Pending write address
	logic [LANES-1:0] wr_lanes_q, wr_lanes_d; // Pending write lanes
	logic drive_q, drive_d; // Internal output drive
	logic low_power_q, low_power_d; // Power-down indication
	logic edge_en; // Edge taken by the array
	logic selected; // All chip selects true
	logic [ADDR_W-1:0] cur_addr; // Word addressed this edge
	logic mem_wr; // Array write this edge
	logic mem_rd; // Array read this edge

	assign edge_en = ~clk_qual_n & ~sleep_s;
	assign selected = ~chip_sel_first_n & chip_sel_second
		& ~chip_sel_third_n;

	// Decode of the new cycle and burst stepping
	always_comb begin
		op_d = op_q;
		base_d = base_q;
		seed_d = seed_q;
		cnt_d = cnt_q;
		wr_pend_d = wr_pend_q;
		wr_addr_d = wr_addr_q;
		wr_lanes_d = wr_lanes_q;
		drive_d = drive_q;
		if (edge_en) begin
			// Load a new access or step the running burst
			if (!burst_advance) begin
				if (selected) begin
					op_d = write_strobe_n ? OP_READ : OP_WRITE;
					base_d = addr_hi;
					seed_d = {burst_seed_bit1, burst_seed_bit0};
					cnt_d = '0;
				end else begin
					op_d = OP_IDLE;
				end
			end else if (op_q != OP_IDLE) begin
				cnt_d = SEED_W'(cnt_q + 1'b1);
			end
			// Reads and writes may alternate every edge
			unique case (op_d)
				OP_READ: begin
					wr_pend_d = 1'b0;
					drive_d = 1'b1;
				end
				OP_WRITE: begin
					wr_pend_d = 1'b1;
					wr_addr_d = cur_addr;
					wr_lanes_d = ~byte_lane_sel_n;
					drive_d = 1'b0;
				end
				default: begin
					wr_pend_d = 1'b0;
					drive_d = 1'b0;
				end
			endcase
		end else if (sleep_s) begin
			// Sleep drops drive, a suspended edge keeps it
			drive_d = 1'b0;
		end
	end

	// Word address for this edge, from next burst position
	assign cur_addr = {base_d, burst_offset(seed_d, cnt_d,
		burst_interleave)};

	// Write data arrives one edge after its address
	assign mem_wr = edge_en & wr_pend_q;
	assign mem_rd = edge_en & (op_d == OP_READ);

	// Power-down in sleep or while deselected
	always_comb begin
		low_power_d = sleep_s | (op_d == OP_IDLE);
	end

	// Access stage registers
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			op_q <= OP_IDLE;
			base_q <= '0;
			seed_q <= '0;
			cnt_q <= '0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			wr_lanes_q <= '0;
			drive_q <= 1'b0;
			low_power_q <= 1'b1;
		end else begin
			op_q <= op_d;
			base_q <= base_d;
			seed_q <= seed_d;
			cnt_q <= cnt_d;
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			wr_lanes_q <= wr_lanes_d;
			drive_q <= drive_d;
			low_power_q <= low_power_d;
		end
	end

	// ========================================
	// Storage array
	fsbs_mem #(
		.ADDR_W(ADDR_W),
		.LANES(LANES),
		.LANE_W(LANE_W)
	) u_mem (
		.clock(clock),
		.wr_en(mem_wr),
		.wr_addr(wr_addr_q),
		.wr_lanes(wr_lanes_q),
		.wr_data(dq_in),
		.rd_en(mem_rd),
		.rd_addr(cur_addr),
		.rd_data(dq_out)
	);

	assign low_power = low_power_q;

	// Output enable gates the drive without waiting for a clock
	assign dq_oe = drive_q & ~out_en_n;

	// ========================================
	// Test access port
	fsbs_tap_t tap_q, tap_d; // Controller state
	logic [IR_W-1:0] ir_q, ir_d; // Active instruction
	logic [IR_W-1:0] irs_q, irs_d; // Instruction shift stage
	logic [ID_W-1:0] drs_q, drs_d; // Data shift stage
	logic tdo_q, tdo_d; // Scan data out
	logic tdo_oe_q, tdo_oe_d; // Scan out drive

	// Next controller state on a scan clock rise
	function automatic fsbs_tap_t tap_next(input fsbs_tap_t s,
		input logic m);
		unique case (s)
			TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			default: tap_next = TAP_RESET; // Illegal code recovers
		endcase
	endfunction : tap_next

	// Capture, shift and update of the scan registers
	always_comb begin
		tap_d = tap_q;
		ir_d = ir_q;
		irs_d = irs_q;
		drs_d = drs_q;
		tdo_d = tdo_q;
		tdo_oe_d = tdo_oe_q;
		if (tck_rise) begin
			tap_d = tap_next(tap_q, tms_s);
			unique case (tap_q)
				TAP_RESET: ir_d = IR_IDCODE;
				TAP_CAP_IR: irs_d = IR_CAPTURE;
				TAP_SHIFT_IR: irs_d = {tdi_s, irs_q[IR_W-1:1]};
				TAP_UPD_IR: ir_d = irs_q;
				TAP_CAP_DR: drs_d = (ir_q == IR_IDCODE) ? ID_CODE : '0;
				TAP_SHIFT_DR: begin
					// Identification shifts all bits, others bypass
					if (ir_q == IR_IDCODE) begin
						drs_d = {tdi_s, drs_q[ID_W-1:1]};
					end else begin
						drs_d[0] = tdi_s;
					end
				end
				default: begin
					ir_d = ir_q;
				end
			endcase
		end else if (tck_fall) begin
			// Scan out changes on the falling scan clock
			tdo_oe_d = (tap_q == TAP_SHIFT_IR) || (tap_q == TAP_SHIFT_DR);
			tdo_d = (tap_q == TAP_SHIFT_IR) ? irs_q[0] : drs_q[0];
		end
	end

	// Scan register state
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			tap_q <= TAP_RESET;
			ir_q <= IR_IDCODE;
			irs_q <= '0;
			drs_q <= '0;
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else begin
			tap_q <= tap_d;
			ir_q <= ir_d;
			irs_q <= irs_d;
			drs_q <= drs_d;
			tdo_q <= tdo_d;
			tdo_oe_q <= tdo_oe_d;
		end
	end

	assign tdo = tdo_q;
	assign tdo_oe = tdo_oe_q;

endmodule : fsbs_top
